/* File: hdl/lpc_defs.svh */
// Register offsets, field positions and reset values of the L4 classifier
`ifndef LPC_DEFS_SVH
`define LPC_DEFS_SVH

`define LPC_ADDR_W          12
`define LPC_ADDR_PORT_BASE  12'h570
`define LPC_ADDR_PRI_BASE   12'h590
`define LPC_ADDR_PRI_PAIR3  12'h593
`define LPC_ADDR_PRI_EN     12'h594
`define LPC_ADDR_DISC_EN    12'h595
`define LPC_ADDR_FLOOR_LO   12'h5a0
`define LPC_ADDR_FLOOR_HI   12'h5a1
`define LPC_ADDR_CEIL_LO    12'h5a2
`define LPC_ADDR_CEIL_HI    12'h5a3
`define LPC_ADDR_CLASS      12'h5a4

`define LPC_CLASS_DROP_BIT  0
`define LPC_CLASS_TX_LSB    1
`define LPC_CLASS_TX_MSB    3
`define LPC_CLASS_MODE_LSB  6
`define LPC_CLASS_MODE_MSB  7

`define LPC_NIB_DROP_BIT    0
`define LPC_NIB_TX_LSB      1
`define LPC_NIB_TX_MSB      3

`define LPC_RST_BYTE        8'h00

`endif

/* File: hdl/lpc_pkg.sv */
// Types shared by the L4 logical port classifier
package lpc_pkg;
    typedef logic [2:0] lpc_pri_t;
    typedef logic [7:0] lpc_byte_t;
    typedef logic [15:0] lpc_port_t;
    typedef enum logic [1:0] {
        LPC_RANGE_NONE = 2'b00,
        LPC_RANGE_EXCL = 2'b01,
        LPC_RANGE_INCL = 2'b10,
        LPC_RANGE_BAD  = 2'b11
    } lpc_range_mode_e;
endpackage

/* File: hdl/lpc_range_check.sv */
// Range comparison of one logical port number against floor and ceiling
`timescale 1ns/1ps
module lpc_range_check #(
    parameter int W = 16
) (
    input  wire logic [W-1:0] portVal,
    input  wire logic [W-1:0] floorVal,
    input  wire logic [W-1:0] ceilVal,
    input  wire logic         rangeOn,
    output logic              inclHit,
    output logic              exclHit
);
    // Strict bounds inside, inclusive bounds outside, so the two never overlap
    assign inclHit = rangeOn && (portVal > floorVal) && (portVal < ceilVal);
    assign exclHit = rangeOn
                  && ((portVal <= floorVal) || (portVal >= ceilVal));
endmodule

/* File: hdl/lpc_classifier.sv */
// L4 logical port classifier: custom ports, range and CPU registers
//
// Behaviour
// - Pair-3 register: port 6 low, 7 high nibble
// - Priority-enable bit n applies port n priority
// - Discard-enable bit n discards port n matches
// - Range floor from low and high bytes
// - Range ceiling from low and high bytes
// - Class register: drop bit0, transmit bits 3:1
// - Mode bits 7:6: none, exclusive, inclusive, invalid
// - Exclusive match: x<=floor or x>=ceiling
// - Inclusive match: floor<x<ceiling, gets range priority unless a priority-enabled custom port matches
// - Custom port number from low/high byte pair
// - Range disabled when ceiling <= floor
`timescale 1ns/1ps
`include "lpc_defs.svh"
module lpc_classifier #(
    parameter int NUM_PORTS = 8
) (
    input  wire logic                    clk_sys,
    input  wire logic                    srst,
    input  wire logic                    ce,
    input  wire logic [`LPC_ADDR_W-1:0]  regAddr,
    input  wire lpc_pkg::lpc_byte_t      regWrData,
    input  wire logic                    regWr,
    input  wire logic                    regRd,
    output lpc_pkg::lpc_byte_t           regRdData,
    output logic                         regRdValid,
    input  wire logic                    frmValid,
    input  wire logic                    frmIsIp,
    input  wire logic                    frmIsTcpUdp,
    input  wire lpc_pkg::lpc_port_t      frmSrcPort,
    input  wire lpc_pkg::lpc_port_t      frmDstPort,
    input  wire lpc_pkg::lpc_pri_t       frmTxPri,
    input  wire logic                    frmDropPri,
    input  wire logic                    frmDiscard,
    output logic                         clsValid,
    output lpc_pkg::lpc_pri_t            clsTxPri,
    output logic                         clsDropPri,
    output logic                         clsDiscard,
    output logic                         clsHitUser,
    output logic                         clsHitRange
);
    import lpc_pkg::*;

    localparam int NUM_PAIRS = NUM_PORTS / 2;

    lpc_byte_t       portLow  [NUM_PORTS];
    lpc_byte_t       portHigh [NUM_PORTS];
    lpc_byte_t       priPair  [NUM_PAIRS];
    logic [NUM_PORTS-1:0] priEn;
    logic [NUM_PORTS-1:0] discEn;
    lpc_byte_t       floorLo;
    lpc_byte_t       floorHi;
    lpc_byte_t       ceilLo;
    lpc_byte_t       ceilHi;
    lpc_pri_t        rangeTx;
    logic            rangeDrop;
    lpc_range_mode_e rangeMode;

    function automatic logic [`LPC_ADDR_W-1:0] port_addr(input int idx,
                                                         input logic hi);
        port_addr = `LPC_ADDR_PORT_BASE + `LPC_ADDR_W'(2 * idx)
                    + {{(`LPC_ADDR_W-1){1'b0}}, hi};
    endfunction

    function automatic logic [`LPC_ADDR_W-1:0] pri_addr(input int idx);
        pri_addr = `LPC_ADDR_PRI_BASE + `LPC_ADDR_W'(idx);
    endfunction

    // Register write decode
    logic [NUM_PORTS-1:0] wrLow;
    logic [NUM_PORTS-1:0] wrHigh;
    logic [NUM_PAIRS-1:0] wrPri;
    logic [NUM_PORTS-1:0] portEq;
    logic [3:0]           portNib [NUM_PORTS];
    lpc_port_t            customPort [NUM_PORTS];

    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
        assign wrLow[g]      = regWr && (regAddr == port_addr(g, 1'b0));
        assign wrHigh[g]     = regWr && (regAddr == port_addr(g, 1'b1));
        assign customPort[g] = {portHigh[g], portLow[g]};
        assign portEq[g]     = (customPort[g] == frmSrcPort)
                             || (customPort[g] == frmDstPort);
        // Even port in the low nibble, odd port in the high nibble
        assign portNib[g]    = priPair[g/2][4*(g%2) +: 4];
    end
    for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
        assign wrPri[p] = regWr && (regAddr == pri_addr(p));
    end

    wire wrPriEn   = regWr && (regAddr == `LPC_ADDR_PRI_EN);
    wire wrDiscEn  = regWr && (regAddr == `LPC_ADDR_DISC_EN);
    wire wrFloorLo = regWr && (regAddr == `LPC_ADDR_FLOOR_LO);
    wire wrFloorHi = regWr && (regAddr == `LPC_ADDR_FLOOR_HI);
    wire wrCeilLo  = regWr && (regAddr == `LPC_ADDR_CEIL_LO);
    wire wrCeilHi  = regWr && (regAddr == `LPC_ADDR_CEIL_HI);
    wire wrClass   = regWr && (regAddr == `LPC_ADDR_CLASS);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                portLow[i]  <= `LPC_RST_BYTE;
                portHigh[i] <= `LPC_RST_BYTE;
            end
            for (int i = 0; i < NUM_PAIRS; i++) begin
                priPair[i] <= `LPC_RST_BYTE;
            end
        end else if (ce) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                if (wrLow[i]) portLow[i] <= regWrData;
                if (wrHigh[i]) portHigh[i] <= regWrData;
            end
            for (int i = 0; i < NUM_PAIRS; i++) begin
                if (wrPri[i]) priPair[i] <= regWrData;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            priEn     <= '0;
            discEn    <= '0;
            floorLo   <= `LPC_RST_BYTE;
            floorHi   <= `LPC_RST_BYTE;
            ceilLo    <= `LPC_RST_BYTE;
            ceilHi    <= `LPC_RST_BYTE;
            rangeTx   <= '0;
            rangeDrop <= 1'b0;
            rangeMode <= LPC_RANGE_NONE;
        end else if (ce) begin
            if (wrPriEn) priEn <= regWrData[NUM_PORTS-1:0];
            if (wrDiscEn) discEn <= regWrData[NUM_PORTS-1:0];
            if (wrFloorLo) floorLo <= regWrData;
            if (wrFloorHi) floorHi <= regWrData;
            if (wrCeilLo) ceilLo <= regWrData;
            if (wrCeilHi) ceilHi <= regWrData;
            if (wrClass) begin
                rangeDrop <= regWrData[`LPC_CLASS_DROP_BIT];
                rangeTx   <= regWrData[`LPC_CLASS_TX_MSB:`LPC_CLASS_TX_LSB];
                rangeMode <= lpc_range_mode_e'(
                    regWrData[`LPC_CLASS_MODE_MSB:`LPC_CLASS_MODE_LSB]);
            end
        end
    end

    // Read-back; reserved class bits and unmapped addresses read zero
    lpc_byte_t rdMux;
    always_comb begin
        rdMux = '0;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (regAddr == port_addr(i, 1'b0)) rdMux = portLow[i];
            if (regAddr == port_addr(i, 1'b1)) rdMux = portHigh[i];
        end
        for (int i = 0; i < NUM_PAIRS; i++) begin
            if (regAddr == pri_addr(i)) rdMux = priPair[i];
        end
        case (regAddr)
            `LPC_ADDR_PRI_EN:   rdMux = 8'(priEn);
            `LPC_ADDR_DISC_EN:  rdMux = 8'(discEn);
            `LPC_ADDR_FLOOR_LO: rdMux = floorLo;
            `LPC_ADDR_FLOOR_HI: rdMux = floorHi;
            `LPC_ADDR_CEIL_LO:  rdMux = ceilLo;
            `LPC_ADDR_CEIL_HI:  rdMux = ceilHi;
            `LPC_ADDR_CLASS:    rdMux = {rangeMode, 2'b00, rangeTx, rangeDrop};
            default:            ;
        endcase
    end

    // Classification
    wire lpc_port_t floorVal = {floorHi, floorLo};
    wire lpc_port_t ceilVal  = {ceilHi, ceilLo};
    wire rangeOn   = ceilVal > floorVal;
    wire inclMode  = rangeMode == LPC_RANGE_INCL;
    wire exclMode  = rangeMode == LPC_RANGE_EXCL;
    wire classify  = frmIsIp && frmIsTcpUdp;

    logic inclSrc;
    logic inclDst;
    logic exclSrc;
    logic exclDst;

    lpc_range_check #(.W(16)) u_rng_src (
        .portVal  (frmSrcPort),
        .floorVal (floorVal),
        .ceilVal  (ceilVal),
        .rangeOn  (rangeOn),
        .inclHit  (inclSrc),
        .exclHit  (exclSrc)
    );
    lpc_range_check #(.W(16)) u_rng_dst (
        .portVal  (frmDstPort),
        .floorVal (floorVal),
        .ceilVal  (ceilVal),
        .rangeOn  (rangeOn),
        .inclHit  (inclDst),
        .exclHit  (exclDst)
    );

    // A frame is inside the range if either port is; outside only if both are
    wire rangeIncl = inclMode && (inclSrc || inclDst);
    wire rangeExcl = exclMode && exclSrc && exclDst;

    // Lowest-numbered enabled matching port supplies the priority
    logic       userPriHit;
    logic [3:0] userNib;
    always_comb begin
        userPriHit = 1'b0;
        userNib    = '0;
        for (int i = NUM_PORTS - 1; i >= 0; i--) begin
            if (portEq[i] && priEn[i]) begin
                userPriHit = 1'b1;
                userNib    = portNib[i];
            end
        end
    end
    wire userDisc = |(portEq & discEn);

    wire lpc_pri_t next_txPri =
        !classify  ? frmTxPri :
        userPriHit ? userNib[`LPC_NIB_TX_MSB:`LPC_NIB_TX_LSB] :
        rangeIncl  ? rangeTx : frmTxPri;
    wire next_dropPri =
        !classify  ? frmDropPri :
        userPriHit ? userNib[`LPC_NIB_DROP_BIT] :
        rangeIncl  ? rangeDrop : frmDropPri;
    // Exclusive range filters: frames outside the window are dropped
    wire next_discard  = frmDiscard
                       || (classify && (userDisc || rangeExcl));
    wire next_hitUser  = frmValid && classify && (|portEq);
    wire next_hitRange = frmValid && classify && (rangeIncl || rangeExcl);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            clsValid    <= 1'b0;
            clsTxPri    <= '0;
            clsDropPri  <= 1'b0;
            clsDiscard  <= 1'b0;
            clsHitUser  <= 1'b0;
            clsHitRange <= 1'b0;
            regRdData   <= '0;
            regRdValid  <= 1'b0;
        end else if (ce) begin
            clsValid    <= frmValid;
            clsTxPri    <= next_txPri;
            clsDropPri  <= next_dropPri;
            clsDiscard  <= next_discard;
            clsHitUser  <= next_hitUser;
            clsHitRange <= next_hitRange;
            regRdData   <= regRd ? rdMux : '0;
            regRdValid  <= regRd;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_nonip_pass: assert property (ce && frmValid && !classify |=>
        clsTxPri == $past(frmTxPri) && clsDropPri == $past(frmDropPri)
        && clsDiscard == $past(frmDiscard) && !clsHitUser)
        else $error("non TCP/UDP frame was altered");
    a_range_off: assert property (ce && (ceilVal <= floorVal)
        |=> !clsHitRange) else $error("range hit while range disabled");
    a_incl_pri: assert property (ce && classify && !userPriHit
        && inclMode && rangeOn && frmSrcPort > floorVal
        && frmSrcPort < ceilVal
        |=> clsTxPri == $past(rangeTx) && clsDropPri == $past(rangeDrop))
        else $error("inclusive match lost range priority");
    a_excl_disc: assert property (ce && frmValid && classify && exclMode
        && rangeOn && (frmSrcPort <= floorVal || frmSrcPort >= ceilVal)
        && (frmDstPort <= floorVal || frmDstPort >= ceilVal)
        |=> clsDiscard && clsHitRange)
        else $error("exclusive match not discarded");
    a_force_disc: assert property (ce && classify
        && (customPort[0] == frmDstPort) && discEn[0] |=> clsDiscard)
        else $error("forced discard missed");
    a_pri_off: assert property (ce && classify && (portEq & priEn) == '0
        && !inclMode |=> clsTxPri == $past(frmTxPri))
        else $error("disabled port priority applied");
    a_pair3_hi: assert property (ce && classify && portEq[7]
        && priEn[7] && (portEq[6:0] & priEn[6:0]) == 7'h00
        |=> clsTxPri == $past(priPair[3][7:5])
        && clsDropPri == $past(priPair[3][4]))
        else $error("port 7 priority not from high nibble");
    a_floor_read: assert property (ce && regRd
        && regAddr == `LPC_ADDR_FLOOR_HI
        |=> regRdValid && regRdData == $past(floorVal[15:8]))
        else $error("floor high byte read wrong");
    a_class_read: assert property (ce && regRd
        && regAddr == `LPC_ADDR_CLASS
        |=> regRdData[5:4] == 2'b00
        && regRdData[7:6] == $past(rangeMode))
        else $error("class register read wrong");
    a_port_write: assert property (ce && wrHigh[2]
        |=> customPort[2][15:8] == $past(regWrData))
        else $error("custom port high byte not used");
endmodule

/* File: sim/lpc_frame_src.sv */
// Frame descriptor source standing in for the switch parser
`timescale 1ns/1ps
module lpc_frame_src (
    input  wire logic         clk_sys,
    output logic              frmValid,
    output logic              frmIsIp,
    output logic              frmIsTcpUdp,
    output lpc_pkg::lpc_port_t frmSrcPort,
    output lpc_pkg::lpc_port_t frmDstPort,
    output lpc_pkg::lpc_pri_t frmTxPri,
    output logic              frmDropPri,
    output logic              frmDiscard
);
    import lpc_pkg::*;
    initial begin
        frmValid = 1'b0;
        {frmIsIp, frmIsTcpUdp, frmSrcPort, frmDstPort} = '0;
        {frmTxPri, frmDropPri, frmDiscard} = '0;
    end
    // One descriptor per call; calls back to back give one per cycle
    task automatic send(input logic ip, tu, input lpc_port_t s, d,
                        input lpc_pri_t tx, input logic dr, ds);
        @(negedge clk_sys);
        frmValid = 1'b1;
        {frmIsIp, frmIsTcpUdp, frmSrcPort, frmDstPort} = {ip, tu, s, d};
        {frmTxPri, frmDropPri, frmDiscard} = {tx, dr, ds};
    endtask
    // Stale fields are inverted so a design that ignores valid is caught
    task automatic idle();
        @(negedge clk_sys);
        frmValid = 1'b0;
        {frmIsIp, frmIsTcpUdp, frmSrcPort, frmDstPort} =
            ~{frmIsIp, frmIsTcpUdp, frmSrcPort, frmDstPort};
        {frmTxPri, frmDropPri, frmDiscard} =
            ~{frmTxPri, frmDropPri, frmDiscard};
    endtask
endmodule

/* File: sim/lpc_classifier_tb.sv */
// Self-checking bench for the L4 logical port classifier
`timescale 1ns/1ps
`include "lpc_defs.svh"
module lpc_classifier_tb;
    import lpc_pkg::*;
    logic                   clk_sys = 1'b0;
    logic                   srst = 1'b1;
    logic                   ce = 1'b1;
    logic [`LPC_ADDR_W-1:0] regAddr = '0;
    lpc_byte_t              regWrData = 8'h00;
    lpc_byte_t              regRdData;
    logic                   regWr = 1'b0;
    logic                   regRd = 1'b0;
    logic                   regRdValid;
    logic                   frmValid, frmIsIp, frmIsTcpUdp;
    logic                   frmDropPri, frmDiscard;
    lpc_port_t              frmSrcPort, frmDstPort;
    lpc_pri_t               frmTxPri, clsTxPri;
    logic                   clsValid, clsDropPri, clsDiscard;
    logic                   clsHitUser, clsHitRange;
    logic [7:0]             mdl [0:4095];
    logic                   dueV = 1'b0;
    logic [6:0]             dueR = '0;
    int                     fails = 0;
    int                     n_compared = 0;

    always #50 clk_sys = ~clk_sys;

    lpc_classifier u_lpc_classifier (
        .clk_sys(clk_sys), .srst(srst), .ce(ce), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .regRdValid(regRdValid),
        .frmValid(frmValid), .frmIsIp(frmIsIp), .frmIsTcpUdp(frmIsTcpUdp),
        .frmSrcPort(frmSrcPort), .frmDstPort(frmDstPort),
        .frmTxPri(frmTxPri), .frmDropPri(frmDropPri),
        .frmDiscard(frmDiscard), .clsValid(clsValid), .clsTxPri(clsTxPri),
        .clsDropPri(clsDropPri), .clsDiscard(clsDiscard),
        .clsHitUser(clsHitUser), .clsHitRange(clsHitRange));

    lpc_frame_src u_lpc_frame_src (
        .clk_sys(clk_sys), .frmValid(frmValid), .frmIsIp(frmIsIp),
        .frmIsTcpUdp(frmIsTcpUdp), .frmSrcPort(frmSrcPort),
        .frmDstPort(frmDstPort), .frmTxPri(frmTxPri),
        .frmDropPri(frmDropPri), .frmDiscard(frmDiscard));

    function automatic logic mapped(input int a);
        return (a >= 'h570 && a <= 'h57f) || (a >= 'h590 && a <= 'h595)
            || (a >= 'h5a0 && a <= 'h5a4);
    endfunction

    function automatic int rng(input int hiAddr);
        return {mdl[hiAddr], mdl[hiAddr-1]};
    endfunction

    // Reference result: {tx, drop, discard, hitUser, hitRange}
    function automatic logic [6:0] predict(input lpc_port_t s, d,
        input logic ok, input lpc_pri_t tx, input logic dr, ds);
        int fl, cl, p;
        logic uHit, uDisc, uPri, inS, inD, rIn, rEx;
        logic [3:0] nib;
        logic [7:0] c;
        {uHit, uDisc, uPri, nib} = '0;
        if (!ok)
            return {tx, dr, ds, 2'b00};
        for (int n = 7; n >= 0; n--) begin
            p = {mdl['h571 + 2*n], mdl['h570 + 2*n]};
            if (p == s || p == d) begin
                uHit = 1'b1;
                uDisc |= mdl[`LPC_ADDR_DISC_EN][n];
                if (mdl[`LPC_ADDR_PRI_EN][n]) begin
                    uPri = 1'b1;
                    c = mdl['h590 + n/2];
                    nib = n[0] ? c[7:4] : c[3:0];
                end
            end
        end
        fl = rng(`LPC_ADDR_FLOOR_HI);
        cl = rng(`LPC_ADDR_CEIL_HI);
        c = mdl[`LPC_ADDR_CLASS];
        inS = s > fl && s < cl;
        inD = d > fl && d < cl;
        rIn = cl > fl && c[7:6] == 2'b10 && (inS || inD);
        rEx = cl > fl && c[7:6] == 2'b01 && !inS && !inD;
        if (uPri)
            {tx, dr} = nib;
        else if (rIn)
            {tx, dr} = c[3:0];
        return {tx, dr, ds | uDisc | rEx, uHit, rIn | rEx};
    endfunction

    function automatic lpc_port_t pick();
        int n;
        n = $urandom % 8;
        case ($urandom % 6)
            0: return 16'(rng(`LPC_ADDR_FLOOR_HI));
            1: return 16'(rng(`LPC_ADDR_FLOOR_HI) + 1);
            2: return 16'(rng(`LPC_ADDR_CEIL_HI) - 1);
            3: return 16'(rng(`LPC_ADDR_CEIL_HI));
            4: return {mdl['h571 + 2*n], mdl['h570 + 2*n]};
            default: return 16'($urandom);
        endcase
    endfunction

    task automatic check(input logic [7:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wr(input int a, input lpc_byte_t d);
        @(negedge clk_sys);
        regAddr = a[11:0];
        regWrData = d;
        regWr = 1'b1;
        if (mapped(a))
            mdl[a] = d;
        @(negedge clk_sys);
        regWr = 1'b0;
    endtask

    // Walks one address below the map to two above, gaps included
    task automatic readAll();
        for (int a = 'h56f; a <= 'h5a6; a++) begin
            @(negedge clk_sys);
            regAddr = a[11:0];
            regRd = 1'b1;
            @(negedge clk_sys);
            regRd = 1'b0;
            // The answer stands one cycle only, so look before it goes
            check(8'(regRdValid), 8'h01);
            check(regRdData, !mapped(a) ? 8'h00 : a == 'h5a4 ?
                  mdl[a] & 8'hcf : mdl[a]);
        end
    endtask

    // Model result lines up with the one-cycle latency and holds with ce
    always @(posedge clk_sys) begin
        if (ce || srst) begin
            dueV <= frmValid && !srst;
            dueR <= predict(frmSrcPort, frmDstPort, frmIsIp && frmIsTcpUdp,
                            frmTxPri, frmDropPri, frmDiscard);
        end
    end

    always @(negedge clk_sys) begin
        if (!srst) begin
            check(8'(clsValid), 8'(dueV));
            if (dueV)
                check({1'b0, clsTxPri, clsDropPri, clsDiscard, clsHitUser,
                       clsHitRange}, {1'b0, dueR});
        end
    end

    initial begin
        repeat (100000) @(posedge clk_sys);
        fails++;
        end_sim();
    end

    initial begin
        foreach (mdl[i])
            mdl[i] = 8'h00;
        void'($urandom(13));
        repeat (3) @(negedge clk_sys);
        srst = 1'b0;
        readAll();
        for (int cfg = 0; cfg < 12; cfg++) begin
            for (int a = 'h56f; a <= 'h5a6; a++)
                wr(a, a == 'h5a4 ? {cfg[1:0], 6'($urandom)} : 8'($urandom));
            wr('h5a3, mdl['h5a1] + 8'(cfg % 3 != 2));
            wr('h5a2, cfg % 3 == 2 ? mdl['h5a0] : 8'($urandom));
            readAll();
            // Random enable gaps: frames seen with ce low are lost to both
            repeat (40) begin
                ce = $urandom % 4 != 0;
                u_lpc_frame_src.send($urandom % 4 != 0, $urandom % 4 != 0,
                    pick(), pick(), 3'($urandom), 1'($urandom),
                    $urandom % 4 == 0);
            end
            ce = 1'b1;
            u_lpc_frame_src.idle();
            repeat (2) @(negedge clk_sys);
        end
        // A second reset must clear every register again
        srst = 1'b1;
        repeat (3) @(negedge clk_sys);
        srst = 1'b0;
        foreach (mdl[i])
            mdl[i] = 8'h00;
        readAll();
        end_sim();
    end
endmodule
